// File: gsup_top.sv
// Bus device general supervisor: startup hold-off, alive telegram, telegram limiter,
// status request trigger and LED power saving, configured over classic Wishbone.
// Assumes all inputs are synchronous to sys_clk and arst_n is asserted on bus voltage return.
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module gsup_top #(
    parameter int unsigned TICK_CYCLES = gsup_pkg::TICK_CYCLES,
    parameter int unsigned N_LED       = gsup_pkg::N_LED_DEF
) (
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             app_valid,
    input  wire logic [7:0]       app_code,
    output logic                  app_ready,
    output logic                  tel_valid,
    output logic      [1:0]       tel_kind,
    output logic      [7:0]       tel_code,
    input  wire logic             tel_ready,
    input  wire logic             req_valid,
    input  wire logic             req_value,
    input  wire logic             btn_press,
    input  wire logic [N_LED-1:0] led_in,
    output logic      [N_LED-1:0] led_out,
    output logic                  active
);

    gsup_pkg::gsup_state_t state, next_state;
    logic [27:0]  tick_cnt, next_tick_cnt;
    logic [7:0]   boot_cnt, next_boot_cnt;
    logic [31:0]  cfg, next_cfg;
    logic [31:0]  lim, next_lim;
    logic [31:0]  next_wb_dat_o;
    logic         next_wb_ack_o;
    logic [16:0]  unit_cnt, next_unit_cnt;
    logic [7:0]   mult_cnt, next_mult_cnt;
    logic [16:0]  per_cnt, next_per_cnt;
    logic [16:0]  led_cnt, next_led_cnt;
    logic [7:0]   sent_cnt, next_sent_cnt;
    logic         alive_pend, next_alive_pend;
    logic         stat_pend, next_stat_pend;
    logic         saving, next_saving;
    logic         next_app_ready, next_tel_valid;
    logic [1:0]   next_tel_kind;
    logic [7:0]   next_tel_code;
    logic [N_LED-1:0] next_led_out;

    logic         tick, run, boundary, allow, free, load_app, load_int, match, alive_fire;
    logic [7:0]   lim_eff;
    logic [3:0]   led_code;

    wire logic [7:0] cfg_delay = cfg[gsup_pkg::CFG_DLY_LSB +: 8];
    wire logic       alive_en  = cfg[gsup_pkg::CFG_ALV_EN];
    wire logic       alive_val = cfg[gsup_pkg::CFG_ALV_VAL];
    wire logic [1:0] alive_unit = cfg[gsup_pkg::CFG_UNIT_LSB +: 2];
    wire logic       lim_en    = cfg[gsup_pkg::CFG_LIM_EN];
    wire logic [3:0] lim_per   = cfg[gsup_pkg::CFG_PER_LSB +: 4];
    wire logic       req_en    = cfg[gsup_pkg::CFG_REQ_EN];
    wire logic [1:0] req_trig  = cfg[gsup_pkg::CFG_TRIG_LSB +: 2];
    wire logic [2:0] led_sel   = cfg[gsup_pkg::CFG_LED_LSB +: 3];
    wire logic [7:0] alive_mult = lim[gsup_pkg::LIM_MULT_LSB +: 8];
    wire logic [7:0] lim_num   = lim[gsup_pkg::LIM_NUM_LSB +: 8];

    always_comb begin
        // Register bus: one wait state, any unmapped word reads zero and acks.
        next_cfg      = cfg;
        next_lim      = lim;
        next_wb_ack_o = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_wb_dat_o = 32'h0000_0000;
        if (next_wb_ack_o) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_we_i && wb_sel_i[b] && wb_adr_i == gsup_pkg::ADR_CFG) begin
                    next_cfg[8*b +: 8] = wb_dat_i[8*b +: 8] & gsup_pkg::MASK_CFG[8*b +: 8];
                end
                if (wb_we_i && wb_sel_i[b] && wb_adr_i == gsup_pkg::ADR_LIM) begin
                    next_lim[8*b +: 8] = wb_dat_i[8*b +: 8] & gsup_pkg::MASK_LIM[8*b +: 8];
                end
            end
            unique case (wb_adr_i)
                gsup_pkg::ADR_CFG:  next_wb_dat_o = cfg;
                gsup_pkg::ADR_LIM:  next_wb_dat_o = lim;
                gsup_pkg::ADR_STAT: next_wb_dat_o = {21'h0, !app_ready && app_valid && run, sent_cnt,
                                                     saving, active};
                default:            next_wb_dat_o = 32'h0000_0000;
            endcase
        end

        // Common one-second tick.
        tick          = tick_cnt == 28'(TICK_CYCLES - 1);
        next_tick_cnt = tick ? 28'h0 : tick_cnt + 28'h1;

        // Startup hold-off counted in whole seconds from bus voltage return.
        next_state    = state;
        next_boot_cnt = boot_cnt;
        unique case (state)
            gsup_pkg::GSUP_WAIT: begin
                if (boot_cnt >= cfg_delay) begin
                    next_state = gsup_pkg::GSUP_RUN;
                end else if (tick) begin
                    next_boot_cnt = boot_cnt + 8'h1;
                end
            end
            gsup_pkg::GSUP_RUN: next_state = gsup_pkg::GSUP_RUN;
        endcase
        run = state == gsup_pkg::GSUP_RUN;

        // Alive timer: unit seconds, then multiplier units; first telegram at startup end.
        next_unit_cnt   = unit_cnt;
        next_mult_cnt   = mult_cnt;
        next_alive_pend = alive_pend && alive_en;
        alive_fire      = 1'b0;
        if (!run || !alive_en) begin
            next_unit_cnt = 17'h0;
            next_mult_cnt = 8'h0;
            next_alive_pend = alive_en && next_state == gsup_pkg::GSUP_RUN && !run;
        end else if (tick) begin
            if (unit_cnt >= gsup_pkg::gsup_unit_secs(alive_unit) - 17'h1) begin
                next_unit_cnt = 17'h0;
                if (mult_cnt + 8'h1 >= alive_mult) begin
                    next_mult_cnt   = 8'h0;
                    alive_fire      = 1'b1;
                    next_alive_pend = 1'b1;
                end else begin
                    next_mult_cnt = mult_cnt + 8'h1;
                end
            end else begin
                next_unit_cnt = unit_cnt + 17'h1;
            end
        end

        // Limiter period; a zero limit is treated as one so traffic never stops for good.
        lim_eff  = (lim_num == 8'h0) ? 8'h1 : lim_num;
        boundary = lim_en && run && tick && per_cnt >= gsup_pkg::gsup_period_secs(lim_per) - 17'h1;
        if (!lim_en || !run || boundary) begin
            next_per_cnt = 17'h0;
        end else begin
            next_per_cnt = tick ? per_cnt + 17'h1 : per_cnt;
        end
        allow = run && (!lim_en || sent_cnt < lim_eff);
        free  = !tel_valid || tel_ready;

        // Status request match.
        unique case (req_trig)
            gsup_pkg::TRIG_OFF: match = !req_value;
            gsup_pkg::TRIG_ON:  match = req_value;
            default:            match = 1'b1;
        endcase
        next_stat_pend = stat_pend || (req_valid && req_en && match && run);

        // Issue: held application telegrams go before internal ones to keep their order.
        load_app       = app_valid && app_ready;
        load_int       = !load_app && free && allow && (alive_pend || stat_pend);
        next_tel_valid = tel_valid && !tel_ready;
        next_tel_kind  = tel_kind;
        next_tel_code  = tel_code;
        if (load_app) begin
            next_tel_valid = 1'b1;
            next_tel_kind  = gsup_pkg::KIND_APP;
            next_tel_code  = app_code;
        end else if (load_int && alive_pend) begin
            next_tel_valid  = 1'b1;
            next_tel_kind   = gsup_pkg::KIND_ALIVE;
            next_tel_code   = {7'h0, alive_val};
            // An expiry in the issuing cycle stays pending, so no interval is lost.
            next_alive_pend = alive_fire;
        end else if (load_int) begin
            next_tel_valid = 1'b1;
            next_tel_kind  = gsup_pkg::KIND_STATUS;
            next_tel_code  = 8'h00;
            // A request arriving in the issuing cycle wins over the clear.
            next_stat_pend = req_valid && req_en && match && run;
        end
        // Follows the enable as it is written, so the count is never stale once limiting is off.
        if (!next_cfg[gsup_pkg::CFG_LIM_EN]) begin
            next_sent_cnt = 8'h0;
        end else if (boundary) begin
            next_sent_cnt = {7'h0, load_app || load_int};
        end else begin
            next_sent_cnt = sent_cnt + {7'h0, load_app || load_int};
        end
        // Back-pressure holds excess application telegrams at the source until the next period.
        next_app_ready = next_state == gsup_pkg::GSUP_RUN && !next_tel_valid
                         && (!lim_en || next_sent_cnt < lim_eff);

        // LED power saving idle timer.
        led_code     = {1'b0, led_sel} + gsup_pkg::LED_CODE_OFS;
        next_led_cnt = led_cnt;
        next_saving  = saving;
        if (btn_press || led_sel == 3'h0 || led_sel > 3'h5) begin
            next_led_cnt = 17'h0;
            next_saving  = 1'b0;
        end else if (tick && !saving) begin
            if (led_cnt >= gsup_pkg::gsup_period_secs(led_code) - 17'h1) begin
                next_saving = 1'b1;
            end else begin
                next_led_cnt = led_cnt + 17'h1;
            end
        end
        next_led_out = next_saving ? '0 : led_in;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state      <= gsup_pkg::GSUP_WAIT;
            tick_cnt   <= 28'h0;
            boot_cnt   <= 8'h0;
            cfg        <= gsup_pkg::RST_CFG;
            lim        <= gsup_pkg::RST_LIM;
            wb_dat_o   <= 32'h0000_0000;
            wb_ack_o   <= 1'b0;
            unit_cnt   <= 17'h0;
            mult_cnt   <= 8'h0;
            per_cnt    <= 17'h0;
            led_cnt    <= 17'h0;
            sent_cnt   <= 8'h0;
            alive_pend <= 1'b0;
            stat_pend  <= 1'b0;
            saving     <= 1'b0;
            app_ready  <= 1'b0;
            tel_valid  <= 1'b0;
            tel_kind   <= gsup_pkg::KIND_APP;
            tel_code   <= 8'h00;
            led_out    <= '0;
            active     <= 1'b0;
        end else begin
            state      <= next_state;
            tick_cnt   <= next_tick_cnt;
            boot_cnt   <= next_boot_cnt;
            cfg        <= next_cfg;
            lim        <= next_lim;
            wb_dat_o   <= next_wb_dat_o;
            wb_ack_o   <= next_wb_ack_o;
            unit_cnt   <= next_unit_cnt;
            mult_cnt   <= next_mult_cnt;
            per_cnt    <= next_per_cnt;
            led_cnt    <= next_led_cnt;
            sent_cnt   <= next_sent_cnt;
            alive_pend <= next_alive_pend;
            stat_pend  <= next_stat_pend;
            saving     <= next_saving;
            app_ready  <= next_app_ready;
            tel_valid  <= next_tel_valid;
            tel_kind   <= next_tel_kind;
            tel_code   <= next_tel_code;
            led_out    <= next_led_out;
            active     <= next_state == gsup_pkg::GSUP_RUN;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_req_hit;
        req_valid && req_en && match && run;
    endsequence
    sequence s_status_due;
        stat_pend && !alive_pend && free && allow && !load_app;
    endsequence

    a_quiet_startup: assert property (!active |-> !tel_valid && !app_ready)
        else $error("telegram activity before startup end");
    a_alive_value: assert property (tel_valid && tel_kind == gsup_pkg::KIND_ALIVE |-> tel_code == {7'h0, alive_val})
        else $error("alive telegram value wrong");
    a_unlimited: assert property (!lim_en |-> sent_cnt == 8'h0)
        else $error("limiter counting while disabled");
    a_limit_cap: assert property (lim_en && !allow |=> !(tel_valid && !$past(tel_valid)) || $past(boundary))
        else $error("telegram issued over the limit");
    a_req_catch: assert property (s_req_hit |=> stat_pend || tel_kind == gsup_pkg::KIND_STATUS)
        else $error("matching status request lost");
    a_status_send: assert property (s_status_due |=> tel_valid && tel_kind == gsup_pkg::KIND_STATUS)
        else $error("status telegram not issued");
    a_led_dark: assert property (saving |-> led_out == '0)
        else $error("LEDs lit during power saving");
    a_led_wake: assert property (btn_press |=> !saving ##1 led_out == $past(led_in))
        else $error("button press did not end power saving");
    a_alive_start: assert property ($rose(run) && alive_en |-> alive_pend)
        else $error("alive telegram not armed at startup end");
    a_period_clear: assert property (boundary |=> sent_cnt <= 8'h1)
        else $error("period boundary did not clear count");
    a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack timing wrong");

endmodule // gsup_top

// File: gsup_pkg.sv
// Constants, types and lookups shared by the bus device general supervisor.
// Assumes a single 200 MHz system clock; all timing is derived from a one-second tick.
package gsup_pkg;

    localparam int unsigned SYS_CLK_HZ  = 200_000_000;
    localparam int unsigned TICK_S      = 1;
    localparam int unsigned TICK_CYCLES = TICK_S * SYS_CLK_HZ;
    localparam int unsigned N_LED_DEF   = 28;

    // Register byte offsets on the bus.
    localparam logic [3:0] ADR_CFG  = 4'h0;
    localparam logic [3:0] ADR_LIM  = 4'h4;
    localparam logic [3:0] ADR_STAT = 4'h8;

    // Field positions of the configuration register.
    localparam int unsigned CFG_DLY_LSB  = 0;
    localparam int unsigned CFG_ALV_EN   = 8;
    localparam int unsigned CFG_ALV_VAL  = 9;
    localparam int unsigned CFG_UNIT_LSB = 10;
    localparam int unsigned CFG_LIM_EN   = 12;
    localparam int unsigned CFG_PER_LSB  = 13;
    localparam int unsigned CFG_REQ_EN   = 17;
    localparam int unsigned CFG_TRIG_LSB = 18;
    localparam int unsigned CFG_LED_LSB  = 20;
    // Field positions of the limit register.
    localparam int unsigned LIM_MULT_LSB = 0;
    localparam int unsigned LIM_NUM_LSB  = 8;
    // Field positions of the status register.
    localparam int unsigned STA_ACTIVE   = 0;
    localparam int unsigned STA_SAVING   = 1;
    localparam int unsigned STA_SENT_LSB = 2;
    localparam int unsigned STA_HOLD     = 10;

    // Reset values: delay 1 s, unit minute, period 1 minute, trigger On; multiplier 1, limit 10.
    localparam logic [31:0] RST_CFG  = 32'h0004_8401;
    localparam logic [31:0] RST_LIM  = 32'h0000_0a01;
    localparam logic [31:0] MASK_CFG = 32'h007f_ffff;
    localparam logic [31:0] MASK_LIM = 32'h0000_ffff;

    localparam logic [16:0] SEC_PER_MIN  = 17'h0003c;
    localparam logic [16:0] SEC_PER_HOUR = 17'h00e10;
    localparam logic [16:0] SEC_PER_DAY  = 17'h15180;

    localparam logic [1:0] KIND_APP    = 2'h0;
    localparam logic [1:0] KIND_ALIVE  = 2'h1;
    localparam logic [1:0] KIND_STATUS = 2'h2;
    localparam logic [1:0] TRIG_OFF    = 2'h0;
    localparam logic [1:0] TRIG_ON     = 2'h1;
    localparam logic [3:0] LED_CODE_OFS = 4'h3;

    typedef enum logic [1:0] {
        GSUP_WAIT = 2'b01,
        GSUP_RUN  = 2'b10
    } gsup_state_t;

    // Period code to seconds: 1, 5, 10, 30 s, then 1, 5, 10, 30, 60 min.
    function automatic logic [16:0] gsup_period_secs(input logic [3:0] code);
        unique case (code)
            4'h0:    return 17'h00001;
            4'h1:    return 17'h00005;
            4'h2:    return 17'h0000a;
            4'h3:    return 17'h0001e;
            4'h4:    return 17'h0003c;
            4'h5:    return 17'h0012c;
            4'h6:    return 17'h00258;
            4'h7:    return 17'h00708;
            default: return 17'h00e10;
        endcase
    endfunction

    function automatic logic [16:0] gsup_unit_secs(input logic [1:0] unit);
        unique case (unit)
            2'h0:    return 17'h00001;
            2'h1:    return SEC_PER_MIN;
            2'h2:    return SEC_PER_HOUR;
            default: return SEC_PER_DAY;
        endcase
    endfunction

endpackage

// File: gsup_bus_taker.sv
// Behavioural model of the bus side that takes outgoing telegrams and logs them.
// Assumes the supervisor offers telegrams with a valid/ready handshake on sys_clk.
`timescale 1ns/1ps
module gsup_bus_taker (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       tel_valid,
    input  wire logic [1:0] tel_kind,
    input  wire logic [7:0] tel_code,
    input  wire logic       active,
    input  wire logic       slow,
    output logic            tel_ready
);
    int         cyc = 0;
    int         n_early = 0;
    logic [1:0] q_kind[$];
    logic [7:0] q_code[$];
    int         q_time[$];

    initial tel_ready = 1'b0;

    // A slow bus accepts only one cycle in four, so the sender must hold its offer.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        tel_ready <= arst_n && (!slow || (cyc % 4) == 3);
        if (tel_valid === 1'b1 && tel_ready === 1'b1) begin
            q_kind.push_back(tel_kind);
            q_code.push_back(tel_code);
            q_time.push_back(cyc);
            if (active !== 1'b1) n_early <= n_early + 1;
        end
    end
endmodule // gsup_bus_taker

// File: gsup_top_test.sv
// Self-checking bench for the general supervisor against a queue model of sent telegrams.
// Assumes a shortened tick of TCK cycles so that configured seconds pass quickly.
`timescale 1ns/1ps
module gsup_top_test;
    localparam int TCK = 40;
    logic        sys_clk = 1'b0;
    logic        arst_n, wb_cyc, wb_stb, wb_we, wb_ack, app_valid, app_ready, tel_valid;
    logic        tel_ready, req_valid, req_value, btn, slow, active;
    logic [3:0]  wb_adr, wb_sel;
    logic [31:0] wb_dat, wb_dat_o, rd;
    logic [7:0]  app_code, tel_code, lims[3];
    logic [1:0]  tel_kind;
    logic [27:0] led_in, led_out, prev;
    integer      seed = 32'h9041_8325;
    int          n_errors = 0;
    int          total_checks = 0;
    int          t0, span, k, hit;
    logic [7:0]  exp_q[$];

    gsup_top #(.TICK_CYCLES(TCK), .N_LED(28)) DUT (
        .sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .app_valid(app_valid), .app_code(app_code),
        .app_ready(app_ready), .tel_valid(tel_valid), .tel_kind(tel_kind), .tel_code(tel_code),
        .tel_ready(tel_ready), .req_valid(req_valid), .req_value(req_value), .btn_press(btn),
        .led_in(led_in), .led_out(led_out), .active(active));
    gsup_bus_taker bus (
        .sys_clk(sys_clk), .arst_n(arst_n), .tel_valid(tel_valid), .tel_kind(tel_kind),
        .tel_code(tel_code), .active(active), .slow(slow), .tel_ready(tel_ready));

    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) led_in <= 28'($random(seed));

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'b11, we, adr, 4'hf, wd};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_dat_o;
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
        @(posedge sys_clk);
        chk(32'(n < 50), 32'h1);
    endtask

    task automatic app_send(input logic [7:0] code);
        int n;
        n = 0;
        {app_valid, app_code} <= {1'b1, code};
        do begin
            @(posedge sys_clk);
            n++;
        end while (app_ready !== 1'b1 && n < 2000);
        app_valid <= 1'b0;
        exp_q.push_back(code);
        @(posedge sys_clk);
    endtask

    task automatic clear_log();
        bus.q_kind.delete();
        bus.q_code.delete();
        bus.q_time.delete();
        exp_q.delete();
    endtask

    task automatic wait_tel(input int cnt, input int lim);
        for (int n = 0; n < lim && bus.q_kind.size() < cnt; n++) @(posedge sys_clk);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        end_sim();
    end

    initial begin
        {arst_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
        {app_valid, app_code, req_valid, req_value, btn, slow} = '0;
        lims = '{8'h01, 8'h03, 8'h00};
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        t0 = bus.cyc;
        // Defaults: delay 1 s, alive off, unit minute, period 1 min, trigger On; limit 10.
        wb_xfer(1'b0, gsup_pkg::ADR_CFG, '0);
        chk(rd, 32'h0004_8401);
        wb_xfer(1'b0, gsup_pkg::ADR_LIM, '0);
        chk(rd, 32'h0000_0a01);
        wb_xfer(1'b1, 4'hc, 32'hffff_ffff);
        wb_xfer(1'b0, 4'hc, '0);
        chk(rd, 32'h0);
        chk(32'(active), 32'h0);
        for (k = 0; k < 4 * TCK && active !== 1'b1; k++) @(posedge sys_clk);
        span = bus.cyc - t0;
        chk(32'(span >= TCK && span <= TCK + 4), 32'h1);
        wb_xfer(1'b1, gsup_pkg::ADR_LIM, 32'h0000_0a02);
        wb_xfer(1'b1, gsup_pkg::ADR_CFG, 32'h0004_8301);
        wait_tel(3, 8 * TCK);
        for (k = 0; k < 3; k++) chk(32'({bus.q_kind[k], bus.q_code[k][0]}), 32'h3);
        span = bus.q_time[2] - bus.q_time[1];
        chk(32'(span >= 2 * TCK - 1 && span <= 2 * TCK + 1), 32'h1);
        chk(32'(bus.n_early), 32'h0);
        foreach (lims[i]) begin
            wb_xfer(1'b1, gsup_pkg::ADR_LIM, {16'h0, lims[i], 8'h01});
            wb_xfer(1'b1, gsup_pkg::ADR_CFG, (lims[i] != 0) ? 32'h0004_1001 : 32'h0004_0001);
            slow <= (lims[i] != 0);
            repeat (2 * TCK) @(posedge sys_clk);
            clear_log();
            repeat (7) app_send(8'($random(seed)));
            wait_tel(7, 10 * TCK);
            for (k = 0; k < 7; k++) chk(32'(bus.q_code[k]), 32'(exp_q[k]));
            span = bus.q_time[6] - bus.q_time[0];
            if (lims[i] == 0) chk(32'(span < TCK), 32'h1);
            else chk(32'(span > ((6 + lims[i]) / lims[i] - 2) * TCK), 32'h1);
        end
        slow <= 1'b0;
        // Walk request enable, trigger settings 0 to 2 and received value through every pairing.
        for (int m = 0; m < 12; m++) begin
            wb_xfer(1'b1, gsup_pkg::ADR_CFG, 32'(1 + (m / 6) * (1 << 17) + ((m % 6) / 2) * (1 << 18)));
            clear_log();
            {req_valid, req_value} <= {1'b1, 1'(m % 2)};
            @(posedge sys_clk);
            req_valid <= 1'b0;
            repeat (8) @(posedge sys_clk);
            hit = (m / 6) && ((m % 6) / 2 == 2 || (m % 6) / 2 == m % 2);
            chk(32'(bus.q_kind.size()), 32'(hit));
            if (hit) chk(32'({bus.q_kind[0], bus.q_code[0]}), 32'h200);
        end
        wb_xfer(1'b1, gsup_pkg::ADR_CFG, 32'h0014_0001);
        btn <= 1'b1;
        @(posedge sys_clk);
        btn <= 1'b0;
        t0 = bus.cyc;
        @(posedge sys_clk);
        prev = led_in;
        for (k = 0; k < 62 * TCK; k++) begin
            @(posedge sys_clk);
            if (led_out !== prev) break;
            prev = led_in;
        end
        span = bus.cyc - t0;
        chk(32'(led_out), 32'h0);
        chk(32'(span >= 59 * TCK && span <= 61 * TCK + 4), 32'h1);
        btn <= 1'b1;
        @(posedge sys_clk);
        btn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        prev = led_in;
        @(posedge sys_clk);
        chk(32'(led_out), 32'(prev));
        end_sim();
    end
endmodule // gsup_top_test
